// file: status_readback_regs.svh
// Constants for the system status read-back block.
// Assumes inclusion by the package and the design file only.
`ifndef STATUS_READBACK_REGS_SVH
`define STATUS_READBACK_REGS_SVH

// Register bus offsets (byte addresses)
`define ADDR_STATUS_WORD 4'h0
`define ADDR_IRQ_STATUS 4'h4
`define ADDR_IRQ_MASK 4'h8
`define ADDR_MODE_SHADOW 4'hC
// Frame fields
`define FRM_SEL_HI 15
`define FRM_SEL_LO 14
`define FRM_RRS_BIT 13
`define FRM_RO_BIT 12
`define FRM_SEL_STATUS 2'h0
// Status word fields
`define ST_CAUSE_HI 11
`define ST_CAUSE_LO 8
`define ST_CAN_WAKE 7
`define ST_LIN_WAKE 6
`define ST_EDGE_WAKE 5
`define ST_ALERT_LVL 4
`define ST_THERMAL 3
`define ST_SWDEV 2
`define ST_ENABLE 1
`define ST_POWER_ON 0
// Reset-cause codes
`define RC_POWER_ON 4'h0
`define RC_CYCLIC_WAKE 4'h1
`define RC_CORE_LOW 4'h2
`define RC_CORE_OVERCUR 4'h3
`define RC_AUX_OVERLOAD 4'h4
`define RC_FLASH_LEFT 4'h5
`define RC_FLASH_READY 4'h6
`define RC_CAN_WAKE 4'h7
`define RC_LIN_WAKE 4'h8
`define RC_LOCAL_WAKE 4'h9
`define RC_FAILSAFE_WAKE 4'hA
`define RC_WD_OVERFLOW 4'hB
`define RC_WD_INIT 4'hC
`define RC_WD_EARLY 4'hD
`define RC_ILLEGAL_SPI 4'hE
`define RC_INT_TIMEOUT 4'hF
// Interrupt status bits
`define IRQ_CAN_WAKE 0
`define IRQ_LIN_WAKE 1
`define IRQ_EDGE_WAKE 2
`define IRQ_RESET_EVT 3
`define IRQ_WIDTH 4

`endif

// file: status_readback_pkg.sv
// Types for the system status read-back block.
// Assumes the constants header is on the include path.
`include "status_readback_regs.svh"
package status_readback_pkg;
  typedef struct packed {
    logic frame_done;
    logic [15:0] data;
  } frame_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic [3:0] last_reset_cause;
    logic can_wakeup_flag;
    logic lin_wakeup_flag;
    logic local_edge_event_flag;
    logic power_on_flag;
    logic [1:0] alert_sync;
    logic alert_prev;
    logic [15:0] frame_rsp;
    logic rsp_pending;
    logic clear_pending;
    logic [15:0] mode_shadow;
    logic mode_write;
    logic [15:0] rdata;
    logic [`IRQ_WIDTH-1:0] irq_status;
    logic [`IRQ_WIDTH-1:0] irq_mask;
    logic irq;
  } state_s;
endpackage

// file: system_status_readback.sv
// System status word read-back for the supply and transceiver companion.
// Assumes the frame engine delivers each received frame with frame_done, one cycle,
// and reports the end of the answer shift with frame_end; event inputs are one-cycle pulses
// from logic on sys_clk_i; the alert pin is asynchronous.
//
// Behaviour
// - The status word is readable in every operating mode.
// - Select bits 15:14 at 00 with bit 13 clear choose the status word.
// - Bit 12 set is pure read; clear also writes payload to mode register.
// - Cause codes 0 power-on, 1 cyclic wake, 2 core supply low.
// - Code 3 core overcurrent in Standby, code 4 aux supply overload in Sleep.
// - Code 5 after leaving Flash mode, code 6 when ready for Flash mode.
// - Codes 7 CAN, 8 LIN, 9 local, 10 fail-safe wake-up.
// - Codes 11 watchdog overflow, 12 init missed, 13 too-early trigger.
// - Code 14 illegal serial access, 15 interrupt service timeout.
// - Bit 7 latches CAN wake-up until a status read clears it.
// - Bit 6 latches LIN wake-up until a status read clears it.
// - Bit 5 latches falling alert edge, cleared by a status read.
// - Bit 4 shows the present alert input level.
// - Bit 3 shows the temperature warning.
// - Bit 2 shows software development mode.
// - Cause field holds the latest reset cause and is never cleared by reads.
// - Bit 1 shows the enable output state.
// - Bit 0 set by power-on reset, cleared after Normal mode entered.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
`include "status_readback_regs.svh"
module system_status_readback
  import status_readback_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire status_readback_pkg::frame_s frame_i,
  input wire logic frame_end_i,
  input wire logic reset_event_i,
  input wire logic [3:0] reset_cause_i,
  input wire logic can_wakeup_i,
  input wire logic lin_wakeup_i,
  input wire logic local_alert_pin_i,
  input wire logic thermal_warning_i,
  input wire logic sw_development_mode_i,
  input wire logic enable_output_state_i,
  input wire logic normal_mode_entered_i,
  input wire status_readback_pkg::bus_req_s bus_i,
  output logic [15:0] frame_rsp_o,
  output logic frame_rsp_valid_o,
  output logic [15:0] mode_reg_o,
  output logic mode_write_o,
  output logic [15:0] bus_rdata_o,
  output logic irq_o
);
  import status_readback_pkg::*;

  state_s s_r;
  state_s s_nxt;
  logic [15:0] status_word;
  logic status_sel;
  logic edge_seen;
  logic [`IRQ_WIDTH-1:0] irq_set;
  logic [`IRQ_WIDTH-1:0] irq_clr;

  always_comb begin
    // Live bits 3:1 sample inputs directly; alert level (synchroniser), flags and cause come from state
    status_word = 16'h0000;
    status_word[`ST_CAUSE_HI:`ST_CAUSE_LO] = s_r.last_reset_cause;
    status_word[`ST_CAN_WAKE] = s_r.can_wakeup_flag;
    status_word[`ST_LIN_WAKE] = s_r.lin_wakeup_flag;
    status_word[`ST_EDGE_WAKE] = s_r.local_edge_event_flag;
    status_word[`ST_ALERT_LVL] = s_r.alert_sync[1];
    status_word[`ST_THERMAL] = thermal_warning_i;
    status_word[`ST_SWDEV] = sw_development_mode_i;
    status_word[`ST_ENABLE] = enable_output_state_i;
    status_word[`ST_POWER_ON] = s_r.power_on_flag;

    // No mode gating: any frame with this selection is answered
    status_sel = frame_i.frame_done
      && (frame_i.data[`FRM_SEL_HI:`FRM_SEL_LO] == `FRM_SEL_STATUS)
      && !frame_i.data[`FRM_RRS_BIT];
    edge_seen = s_r.alert_prev && !s_r.alert_sync[1];

    irq_set = '0;
    irq_set[`IRQ_CAN_WAKE] = can_wakeup_i;
    irq_set[`IRQ_LIN_WAKE] = lin_wakeup_i;
    irq_set[`IRQ_EDGE_WAKE] = edge_seen;
    irq_set[`IRQ_RESET_EVT] = reset_event_i;
    irq_clr = '0;
    if (bus_i.wr && bus_i.addr == `ADDR_IRQ_STATUS) begin
      irq_clr = bus_i.wdata[`IRQ_WIDTH-1:0];
    end

    s_nxt = s_r;
    s_nxt.alert_sync = {s_r.alert_sync[0], local_alert_pin_i};
    s_nxt.alert_prev = s_r.alert_sync[1];
    s_nxt.mode_write = 1'b0;
    s_nxt.rsp_pending = 1'b0;

    if (status_sel) begin
      s_nxt.frame_rsp = status_word;
      s_nxt.rsp_pending = 1'b1;
      s_nxt.clear_pending = 1'b1;
      if (!frame_i.data[`FRM_RO_BIT]) begin
        s_nxt.mode_shadow = frame_i.data;
        s_nxt.mode_write = 1'b1;
      end
    end

    // Clear at frame end only what the host was shown; later events survive
    if (frame_end_i && s_r.clear_pending) begin
      s_nxt.clear_pending = 1'b0;
      s_nxt.can_wakeup_flag = s_r.can_wakeup_flag & ~s_r.frame_rsp[`ST_CAN_WAKE];
      s_nxt.lin_wakeup_flag = s_r.lin_wakeup_flag & ~s_r.frame_rsp[`ST_LIN_WAKE];
      s_nxt.local_edge_event_flag = s_r.local_edge_event_flag & ~s_r.frame_rsp[`ST_EDGE_WAKE];
    end
    if (can_wakeup_i) begin
      s_nxt.can_wakeup_flag = 1'b1;
    end
    if (lin_wakeup_i) begin
      s_nxt.lin_wakeup_flag = 1'b1;
    end
    if (edge_seen) begin
      s_nxt.local_edge_event_flag = 1'b1;
    end

    // Cause is only ever overwritten by a new reset event
    if (reset_event_i) begin
      s_nxt.last_reset_cause = reset_cause_i;
      if (reset_cause_i == `RC_POWER_ON) begin
        s_nxt.power_on_flag = 1'b1;
      end
    end
    if (normal_mode_entered_i && !(reset_event_i && reset_cause_i == `RC_POWER_ON)) begin
      s_nxt.power_on_flag = 1'b0;
    end

    // Register bus
    if (bus_i.wr && bus_i.addr == `ADDR_IRQ_MASK) begin
      s_nxt.irq_mask = bus_i.wdata[`IRQ_WIDTH-1:0];
    end
    s_nxt.irq_status = (s_r.irq_status & ~irq_clr) | irq_set;
    s_nxt.irq = |(s_r.irq_status & s_r.irq_mask);
    s_nxt.rdata = 16'h0000;
    if (bus_i.rd) begin
      case (bus_i.addr)
        `ADDR_STATUS_WORD: s_nxt.rdata = status_word;
        `ADDR_IRQ_STATUS: s_nxt.rdata = {{(16-`IRQ_WIDTH){1'b0}}, s_r.irq_status};
        `ADDR_IRQ_MASK: s_nxt.rdata = {{(16-`IRQ_WIDTH){1'b0}}, s_r.irq_mask};
        `ADDR_MODE_SHADOW: s_nxt.rdata = s_r.mode_shadow;
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      s_r <= '0;
      s_r.last_reset_cause <= `RC_POWER_ON;
      s_r.power_on_flag <= 1'b1;
      s_r.alert_sync <= 2'h3;
      s_r.alert_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign frame_rsp_o = s_r.frame_rsp;
  assign frame_rsp_valid_o = s_r.rsp_pending;
  assign mode_reg_o = s_r.mode_shadow;
  assign mode_write_o = s_r.mode_write;
  assign bus_rdata_o = s_r.rdata;
  assign irq_o = s_r.irq;
endmodule // system_status_readback

// file: status_readback_checker.sv
// Concurrent checks on the status read-back block.
// Bound to the design top; sees its ports only.
`timescale 1ns/10ps
module status_readback_checker (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire status_readback_pkg::frame_s frame_i,
  input wire logic can_wakeup_i,
  input wire logic thermal_warning_i,
  input wire logic sw_development_mode_i,
  input wire logic enable_output_state_i,
  input wire status_readback_pkg::bus_req_s bus_i,
  input wire logic [15:0] frame_rsp_o,
  input wire logic frame_rsp_valid_o,
  input wire logic [15:0] mode_reg_o,
  input wire logic mode_write_o,
  input wire logic [15:0] bus_rdata_o
);
  import status_readback_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence st_sel;
    frame_i.frame_done && frame_i.data[15:13] == 3'h0;
  endsequence
  sequence st_rd;
    st_sel ##0 frame_i.data[12];
  endsequence
  answer_valid_a: assert property (st_sel |=> frame_rsp_valid_o)
    else $error("status frame not answered");
  other_sel_a: assert property (frame_i.frame_done && frame_i.data[15:13] != 3'h0 |=> !frame_rsp_valid_o)
    else $error("answer to a foreign selection");
  valid_cause_a: assert property (frame_rsp_valid_o |-> $past(frame_i.frame_done))
    else $error("answer without a frame");
  mode_write_a: assert property (st_sel ##0 !frame_i.data[12] |=> mode_write_o && mode_reg_o == $past(frame_i.data))
    else $error("mode register not written");
  pure_read_a: assert property (st_rd |=> !mode_write_o)
    else $error("pure read wrote mode register");
  live_bits_a: assert property (st_sel |=> frame_rsp_o[3] == $past(thermal_warning_i) &&
    frame_rsp_o[2] == $past(sw_development_mode_i) && frame_rsp_o[1] == $past(enable_output_state_i))
    else $error("level bits wrong");
  can_flag_a: assert property (can_wakeup_i ##1 st_sel |=> frame_rsp_o[7])
    else $error("wake flag missing");
  answer_hold_a: assert property (!frame_i.frame_done |=> $stable(frame_rsp_o))
    else $error("answer changed without frame");
  unmapped_read_a: assert property (bus_i.rd && bus_i.addr[1:0] != 2'h0 |=> bus_rdata_o == 16'h0)
    else $error("unmapped read not zero");
endmodule // status_readback_checker

bind system_status_readback status_readback_checker chk_inst (.sys_clk_i, .sys_rst_i, .frame_i, .can_wakeup_i,
  .thermal_warning_i, .sw_development_mode_i, .enable_output_state_i, .bus_i, .frame_rsp_o, .frame_rsp_valid_o,
  .mode_reg_o, .mode_write_o, .bus_rdata_o);

// file: host_model.sv
// Host side model: sends one frame and closes it after the answer.
// Assumes each call starts just after a rising clock edge.
`timescale 1ns/10ps
module host_model (
  input wire logic sys_clk_i,
  input wire logic [15:0] frame_rsp_i,
  output status_readback_pkg::frame_s frame_o,
  output logic frame_end_o
);
  import status_readback_pkg::*;
  initial begin
    frame_o = '0;
    frame_end_o = 1'b0;
  end
  // Between frames the data lines show the inverse of the last word
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    frame_o <= '{1'b1, cmd};
    @(posedge sys_clk_i);
    frame_o <= '{1'b0, ~cmd};
    @(posedge sys_clk_i);
    rsp = frame_rsp_i;
    frame_end_o <= 1'b1;
    @(posedge sys_clk_i);
    frame_end_o <= 1'b0;
  endtask
endmodule // host_model

// file: testbench.sv
// Self-checking bench for the status read-back block.
// Host model sends frames; the bench drives events and the register port.
`timescale 1ns/10ps
module testbench;
  import status_readback_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rev = 1'b0, can = 1'b0, lin = 1'b0, pin = 1'b1;
  logic thr = 1'b0, swd = 1'b0, ena = 1'b0, nme = 1'b0, fend, vld, mwr, irq;
  logic [3:0] cause = 4'h0;
  logic [15:0] rsp, mreg, rdata, w;
  bus_req_s bus = '0;
  frame_s frm;
  int mismatches = 0, n_compared = 0;
  system_status_readback system_status_readback_inst (.sys_clk_i(clk), .sys_rst_i(rst), .frame_i(frm),
    .frame_end_i(fend), .reset_event_i(rev), .reset_cause_i(cause), .can_wakeup_i(can), .lin_wakeup_i(lin),
    .local_alert_pin_i(pin), .thermal_warning_i(thr), .sw_development_mode_i(swd), .enable_output_state_i(ena),
    .normal_mode_entered_i(nme), .bus_i(bus), .frame_rsp_o(rsp), .frame_rsp_valid_o(vld), .mode_reg_o(mreg),
    .mode_write_o(mwr), .bus_rdata_o(rdata), .irq_o(irq));
  host_model host_model_inst (.sys_clk_i(clk), .frame_rsp_i(rsp), .frame_o(frm), .frame_end_o(fend));
  initial begin
    forever #25 clk = ~clk;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task rs;
    host_model_inst.xfer(16'h1000, w);
  endtask
  task bw(input logic [3:0] a, input logic [15:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task br(input logic [3:0] a);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
    w = rdata;
  endtask
  task t_power;
    rs; chk(w, 16'h0011);
    nme <= 1'b1; @(posedge clk); nme <= 1'b0;
    rs; chk(w, 16'h0010);
  endtask
  task t_cause;
    for (int i = 15; i >= 0; i--) begin
      cause <= i[3:0]; rev <= 1'b1; @(posedge clk); rev <= 1'b0;
      rs; rs; chk(w & 16'h0F00, {4'h0, i[3:0], 8'h0});
    end
  endtask
  task t_wake;
    pin <= 1'b0; repeat (6) @(posedge clk);
    lin <= 1'b1; @(posedge clk); lin <= 1'b0;
    can <= 1'b1; @(posedge clk); can <= 1'b0;
    rs; chk(w & 16'h00F0, 16'h00E0);
    rs; chk(w & 16'h00F0, 16'h0000);
    pin <= 1'b1; repeat (6) @(posedge clk);
    rs; chk(w & 16'h00F0, 16'h0010);
  endtask
  task t_lvl;
    {thr, swd, ena} <= 3'b101; @(posedge clk);
    rs; chk(w & 16'h000E, 16'h000A);
    {thr, swd, ena} <= 3'b010; @(posedge clk);
    rs; chk(w & 16'h000E, 16'h0004);
  endtask
  task t_mode;
    host_model_inst.xfer(16'h0ABC, w); chk(mreg, 16'h0ABC);
    host_model_inst.xfer(16'h1555, w); chk(mreg, 16'h0ABC);
    host_model_inst.xfer(16'h2123, w); chk(mreg, 16'h0ABC);
    br(4'hC); chk(w, 16'h0ABC);
  endtask
  task t_irq;
    bw(4'h4, 16'h000F); bw(4'h8, 16'h0001);
    can <= 1'b1; @(posedge clk); can <= 1'b0; repeat (2) @(posedge clk);
    chk({15'h0, irq}, 16'h0001);
    bw(4'h8, 16'h0000); @(posedge clk); chk({15'h0, irq}, 16'h0000);
    br(4'h4); chk(w & 16'h0001, 16'h0001);
    bw(4'h4, 16'h0001); br(4'h4); chk(w, 16'h0000);
    br(4'h2); chk(w, 16'h0000);
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_power; t_cause; t_wake; t_lvl; t_mode; t_irq;
    conclude;
  end
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude;
  end
endmodule // testbench
